// [rtl/trig_status_pkg.sv]
// Package for the trigger status block: offsets, field layout, reset values, carriers.
// Assumes a single hclk domain and an AHB-Lite register bus with 32-bit data.
package trig_status_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_CH    = 6;
    localparam int EV_W      = 4;
    localparam int LOW_CH    = 4;   // Channels held in the low status register

    // ****************************************************************
    // Register map (byte addresses within the block)
    // ****************************************************************
    localparam logic [7:0] STATUS_LOW_OFS  = 8'h70;
    localparam logic [7:0] STATUS_HIGH_OFS = 8'h74;
    localparam logic [7:0] ENABLE_OFS      = 8'h7c;   // Trigger enables
    localparam logic [7:0] MODE_OFS        = 8'h80;   // Counting mode per channel

    localparam logic [31:0] STATUS_LOW_RST  = 32'h0000_0000;
    localparam logic [31:0] STATUS_HIGH_RST = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RST      = 32'h0000_0000;
    localparam logic [31:0] MODE_RST        = 32'h0000_0000;

    // ****************************************************************
    // Field layout of one channel nibble, one byte lane per channel
    // ****************************************************************
    localparam int FLD_RISE   = 0;
    localparam int FLD_RELOAD = 1;
    localparam int FLD_FALL   = 2;
    localparam int FLD_PERIOD = 3;
    localparam int LANE_W     = 8;

    // AHB-Lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    // One channel's counter events, each a one-cycle pulse
    typedef struct packed {
        logic period;
        logic fall_cmp;
        logic reload;
        logic rise_cmp;
    } chan_ev_s;

    // Decoded register access for one data phase
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  ofs;
    } reg_acc_s;

endpackage

// [rtl/trig_flag_cell.sv]
// One channel's four sticky trigger flags with write-one-to-clear.
// Assumes events are one-cycle pulses already gated by enables and mode.
module trig_flag_cell
    import trig_status_pkg::*;
(
    // Clock and reset
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    // Event and clear
    input  wire trig_status_pkg::chan_ev_s     ev,
    input  wire logic [trig_status_pkg::EV_W-1:0] clr,
    // Flags
    output logic [trig_status_pkg::EV_W-1:0]   flags
);
    logic [EV_W-1:0] ev_bits;

    // Nibble order: period, falling compare, reload match, rising compare
    assign ev_bits = {ev.period, ev.fall_cmp, ev.reload, ev.rise_cmp};

    // Set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clr) | ev_bits;   // [R5] [R10]
        end
    end
endmodule

// [rtl/trig_status.sv]
// Top of the trigger status block: event gating, flag storage, AHB-Lite slave.
// Assumes counter events arrive as one-cycle pulses on hclk from the PWM counters.

// What this block does
// R1 - Period reached sets period flag, triggers converter
// R2 - Down-count compare match sets falling flag
// R3 - Reload value match sets reload flag
// R4 - Up-count compare match sets rising flag
// R5 - Flags sticky; write one clears them
// R6 - Low register 0x70 holds channels 0-3
// R7 - High register 0x74 holds channels 4-5
// R8 - Each event type has own enable
// R9 - Reload and rising only in center mode
// R10 - Set beats simultaneous clear
module trig_status
    import trig_status_pkg::*;
#(
    parameter int CH = trig_status_pkg::NUM_CH
)
(
    // Clock and reset
    input  wire logic                              hclk,
    input  wire logic                              hresetn,
    // AHB-Lite slave
    input  wire logic                              hsel,
    input  wire logic [31:0]                       haddr,
    input  wire logic [1:0]                        htrans,
    input  wire logic                              hwrite,
    input  wire logic [2:0]                        hsize,
    input  wire logic [31:0]                       hwdata,
    input  wire logic                              hready,
    output logic [31:0]                            hrdata,
    output logic                                   hreadyout,
    output logic                                   hresp,
    // Counter events, one pulse each
    input  wire trig_status_pkg::chan_ev_s [CH-1:0] ch_ev,
    // Converter trigger
    output logic                                   adc_trigger
);
    import trig_status_pkg::*;

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    reg_acc_s              acc_r;
    logic [31:0]           enable_r;       // Nibble per channel, same order as flags
    logic [CH-1:0]         center_mode_r;  // 1 = center aligned counting
    logic [EV_W-1:0]       flags    [CH];
    logic [EV_W-1:0]       clr      [CH];
    chan_ev_s [CH-1:0]     gated_ev;
    logic [CH-1:0]         ch_fire;
    logic [31:0]           status_low;
    logic [31:0]           status_high;
    logic [31:0]           rdata_nxt;
    logic                  addr_ok;

    // Byte lane of a channel within its status register
    function automatic int lane_pos(input int ch);
        return (ch < LOW_CH) ? ch * LANE_W : (ch - LOW_CH) * LANE_W;
    endfunction

    // Enable nibble of a channel in the enable register
    function automatic logic [EV_W-1:0] en_of(input logic [31:0] en, input int ch);
        return en[ch*EV_W +: EV_W];
    endfunction

    // ****************************************************************
    // Bus address phase capture
    // ****************************************************************
    assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

    // The slave never stalls, so a write's data phase is always the next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_r <= '0;
        end else if (hready) begin
            acc_r.wr  <= addr_ok && hwrite;
            acc_r.rd  <= addr_ok && !hwrite;
            acc_r.ofs <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;   // Always OKAY; unmapped reads return zero

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // Enables: software picks which events may trigger the converter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_r <= ENABLE_RST;
        end else if (acc_r.wr && acc_r.ofs == ENABLE_OFS) begin
            enable_r <= {{(32-CH*EV_W){1'b0}}, hwdata[CH*EV_W-1:0]};
        end
    end

    // Counting mode; only the low channel bits are kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            center_mode_r <= MODE_RST[CH-1:0];
        end else if (acc_r.wr && acc_r.ofs == MODE_OFS) begin
            center_mode_r <= hwdata[CH-1:0];
        end
    end

    // ****************************************************************
    // Event gating and flag storage
    // ****************************************************************
    // Disabled events neither flag nor trigger; reload and rising need center mode
    always_comb begin
        logic [EV_W-1:0] en_c;
        en_c = '0;
        for (int c = 0; c < CH; c++) begin
            // A function result cannot be bit-selected, so take the nibble first
            en_c = en_of(enable_r, c);
            gated_ev[c].period   = ch_ev[c].period   && en_c[FLD_PERIOD];     // [R1] [R8]
            gated_ev[c].fall_cmp = ch_ev[c].fall_cmp && en_c[FLD_FALL];       // [R2] [R8]
            gated_ev[c].reload   = ch_ev[c].reload   && en_c[FLD_RELOAD]
                                   && center_mode_r[c];                       // [R3] [R9]
            gated_ev[c].rise_cmp = ch_ev[c].rise_cmp && en_c[FLD_RISE]
                                   && center_mode_r[c];                       // [R4] [R9]
            ch_fire[c] = |gated_ev[c];
        end
    end

    // Write-one-to-clear decode per channel from its own register and lane
    always_comb begin
        for (int c = 0; c < CH; c++) begin
            if (c < LOW_CH) begin
                clr[c] = (acc_r.wr && acc_r.ofs == STATUS_LOW_OFS)
                         ? hwdata[lane_pos(c) +: EV_W] : '0;                  // [R5] [R6]
            end else begin
                clr[c] = (acc_r.wr && acc_r.ofs == STATUS_HIGH_OFS)
                         ? hwdata[lane_pos(c) +: EV_W] : '0;                  // [R5] [R7]
            end
        end
    end

    for (genvar g = 0; g < CH; g++) begin : g_cell
        trig_flag_cell u_cell (
            .hclk    (hclk),
            .hresetn (hresetn),
            .ev      (gated_ev[g]),
            .clr     (clr[g]),
            .flags   (flags[g])
        );
    end

    // Trigger pulse registered so the converter sees a clean one-cycle strobe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adc_trigger <= 1'b0;
        end else begin
            adc_trigger <= |ch_fire;   // [R1] [R8]
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Reserved upper nibbles of each lane read as zero
    always_comb begin
        status_low  = STATUS_LOW_RST;
        status_high = STATUS_HIGH_RST;
        for (int c = 0; c < CH; c++) begin
            if (c < LOW_CH) begin
                status_low[lane_pos(c) +: EV_W]  = flags[c];   // [R6]
            end else begin
                status_high[lane_pos(c) +: EV_W] = flags[c];   // [R7]
            end
        end
    end

    // Read data is sampled in the address phase so it stands during the data phase
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (haddr[7:0])
            STATUS_LOW_OFS:  rdata_nxt = status_low;
            STATUS_HIGH_OFS: rdata_nxt = status_high;
            ENABLE_OFS:      rdata_nxt = enable_r;
            MODE_OFS:        rdata_nxt = {{(32-CH){1'b0}}, center_mode_r};
            default:         rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rdata_nxt;
        end
    end
endmodule

// [testbench/trig_status_props.sv]
// Checker for the trigger status block, bound to its top module.
// Assumes one hclk domain and a zero-wait AHB-Lite slave.
module trig_status_props
    import trig_status_pkg::*;
#(
    parameter int CH = NUM_CH
)
(
    // Clock and reset
    input  wire logic                               hclk,
    input  wire logic                               hresetn,
    // Bus
    input  wire logic                               hsel,
    input  wire logic [31:0]                        haddr,
    input  wire logic [1:0]                         htrans,
    input  wire logic                               hwrite,
    input  wire logic                               hready,
    input  wire logic [31:0]                        hrdata,
    input  wire logic                               hreadyout,
    input  wire logic                               hresp,
    // Events and trigger
    input  wire trig_status_pkg::chan_ev_s [CH-1:0] ch_ev,
    input  wire logic                               adc_trigger
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       rd_ph_r;
    logic [7:0] ofs_r;
    wire        rd_req = hsel & hready & htrans[1] & !hwrite;
    // Track which register the current read data phase belongs to
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ph_r <= 1'b0;
            ofs_r   <= 8'h00;
        end else begin
            rd_ph_r <= rd_req;
            ofs_r   <= haddr[7:0];
        end
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave stalled or signalled an error");
    a_trig_cause: assert property (adc_trigger |-> $past(|ch_ev))
        else $error("trigger without a counter event");
    a_trig_quiet: assert property (!(|ch_ev) |=> !adc_trigger)
        else $error("trigger after an idle cycle");
    a_low_reserved: assert property (rd_ph_r && ofs_r == STATUS_LOW_OFS |->
        (hrdata & 32'hf0f0_f0f0) == 32'h0) else $error("low status reserved bits set");
    a_high_reserved: assert property (rd_ph_r && ofs_r == STATUS_HIGH_OFS |->
        (hrdata & 32'hffff_f0f0) == 32'h0) else $error("high status reserved bits set");
    a_unmapped_zero: assert property (rd_ph_r && ofs_r == 8'h78 |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_enable_upper: assert property (rd_ph_r && ofs_r == ENABLE_OFS |-> hrdata[31:24] == 8'h0)
        else $error("enable upper bits set");
    a_rdata_hold: assert property (!rd_req |=> $stable(hrdata))
        else $error("read data moved without a read");
    // Main scenarios reached
    c_flag_read: cover property (rd_ph_r && ofs_r == STATUS_LOW_OFS && hrdata != 32'h0);
    c_trigger: cover property (adc_trigger);
    c_clear: cover property (hsel && htrans[1] && hwrite && haddr[7:0] == STATUS_LOW_OFS);
endmodule

bind trig_status trig_status_props #(.CH(CH)) trig_status_props_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ch_ev(ch_ev), .adc_trigger(adc_trigger));

// [testbench/adc_trig_sink.sv]
// Behavioural converter trigger input: counts conversion starts.
// Assumes adc_trigger is a one-cycle pulse on hclk.
module adc_trig_sink (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Trigger from the status block
    input  wire logic adc_trigger,
    // Conversions started
    output int        starts
);
    // Each sampled pulse starts exactly one conversion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) starts <= 0;
        else if (adc_trigger) starts <= starts + 1;
    end
endmodule

// [testbench/trig_status_bench.sv]
// Bench for the trigger status block: bus master, event driver, converter model.
// Assumes a zero-wait slave; hready loops back from hreadyout.
module trig_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import trig_status_pkg::*;
    logic                  hclk, hresetn, hsel, hwrite, hreadyout, hresp, adc_trigger;
    logic [31:0]           haddr, hwdata, hrdata, rd;
    logic [1:0]            htrans;
    logic [2:0]            hsize;
    chan_ev_s [NUM_CH-1:0] ch_ev;
    int                    starts, fail_count, samples_checked;

    trig_status #(.CH(NUM_CH)) trig_status_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ch_ev(ch_ev), .adc_trigger(adc_trigger));
    adc_trig_sink adc_trig_sink_inst (.hclk(hclk), .hresetn(hresetn),
        .adc_trigger(adc_trigger), .starts(starts));

    // 200 MHz clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask
    // Bounded wait; a stuck slave ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            close_out();
        end
    endtask
    // One transfer; ev pulses in the data phase so a set can meet a clear
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d, chan_ev_s [NUM_CH-1:0] ev);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        ch_ev  <= ev;
        wait_rdy();
        rd = hrdata;
        ch_ev <= '0;
    endtask
    task automatic rdchk(string what, logic [7:0] a, logic [31:0] exp);
        bus(1'b0, a, 32'h0, '0);
        check(what, rd, exp);
    endtask
    // Every event of every channel at once, then time for the trigger to land
    task automatic pulse();
        @(posedge hclk);
        ch_ev <= '1;
        @(posedge hclk);
        ch_ev <= '0;
        repeat (2) @(posedge hclk);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic mode_gating();
        bus(1'b1, ENABLE_OFS, 32'hffff_ffff, '0);
        rdchk("enable", ENABLE_OFS, 32'h00ff_ffff);
        pulse();
        rdchk("low edge", STATUS_LOW_OFS, 32'h0c0c_0c0c);
        rdchk("high edge", STATUS_HIGH_OFS, 32'h0000_0c0c);
        bus(1'b1, MODE_OFS, 32'h0000_003f, '0);
        rdchk("mode", MODE_OFS, 32'h0000_003f);
        pulse();
        rdchk("low center", STATUS_LOW_OFS, 32'h0f0f_0f0f);
        rdchk("high center", STATUS_HIGH_OFS, 32'h0000_0f0f);
        check("starts", starts, 32'h2);
    endtask
    task automatic clear_gating();
        chan_ev_s [NUM_CH-1:0] ev;
        ev = '0;
        ev[2].fall_cmp = 1'b1;
        bus(1'b1, STATUS_LOW_OFS, 32'h0000_0f01, '0);
        rdchk("low w1c", STATUS_LOW_OFS, 32'h0f0f_000e);
        bus(1'b1, STATUS_HIGH_OFS, 32'hffff_ffff, '0);
        rdchk("high w1c", STATUS_HIGH_OFS, 32'h0);
        bus(1'b1, STATUS_LOW_OFS, 32'hffff_ffff, '0);
        bus(1'b1, ENABLE_OFS, 32'h0, '0);
        pulse();
        rdchk("low off", STATUS_LOW_OFS, 32'h0);
        bus(1'b1, ENABLE_OFS, 32'h0000_0400, '0);
        pulse();
        rdchk("low one", STATUS_LOW_OFS, 32'h0004_0000);
        bus(1'b1, STATUS_LOW_OFS, 32'h0004_0000, ev);
        rdchk("low race", STATUS_LOW_OFS, 32'h0004_0000);
        check("starts", starts, 32'h4);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        ch_ev = '0;
        fail_count = 0;
        samples_checked = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk("low reset", STATUS_LOW_OFS, STATUS_LOW_RST);
        rdchk("high reset", STATUS_HIGH_OFS, STATUS_HIGH_RST);
        rdchk("unmapped", 8'h78, 32'h0);
        mode_gating();
        clear_gating();
        close_out();
    end
endmodule
